// ===== bench/dds_waveform_core_trigger_io_bench.sv
// top bench: drives the core over apb, compares ports with an integer model
// assumes the far model supplies the power-up table load
`timescale 1ns/1ps
module dds_waveform_core_trigger_io_bench;
  logic        core_clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        lv, le, et, ckw, cko, ckoe, sqc, filt, moe, eck, plk, sync, tst;
  logic [9:0]  ld, dac, prev, idx;
  logic [1:0]  tso;
  int          n_mismatch, total_checks, cyc, step, r, s;
  int unsigned seed;
  int          sh[4] = '{0, 2, 3, 4};
  dwc_core i_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .load_valid_i(lv), .load_data_i(ld), .load_err_i(le), .ext_trig_i(et),
    .ck_sock_i(ckw), .ck_sock_o(cko), .ck_sock_oe_o(ckoe), .dac_data_o(dac),
    .sq_comp_sel_o(sqc), .filt_en_o(filt), .main_out_en_o(moe), .ext_clk_sel_o(eck),
    .plock_en_o(plk), .tso_level_o(tso), .sync_out_o(sync), .trig_start_o(tst));
  dwc_far_model i_far (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ck_oe_i(ckoe),
    .ck_drv_i(cko), .ck_wire_o(ckw), .load_valid_o(lv), .load_data_o(ld), .load_err_o(le),
    .ext_trig_o(et));
  // 40 mhz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // hang guard sized well above the full run
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);  // only the bench timeout ends a lost answer
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_b_i, cyc, seed} = '0;
    seed = 77;
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    apb(1'b1, dwc_pkg::A_CTRL, 32'h0000_0833);
    apb(1'b0, dwc_pkg::A_STAT, 32'h0);
    chk("status", {4'b0100, dwc_pkg::SW_REV}, rd[11:0]);
    apb(1'b0, dwc_pkg::A_CTRL, 32'h0);
    chk("ctrl", dwc_pkg::CTRL_RST, rd);
    chk("ck oe", 1, ckoe);
    tick(1100);
    apb(1'b0, dwc_pkg::A_STAT, 32'h0);
    chk("loaded", 0, rd[11:10]);
    chk("main out", 0, moe);
    apb(1'b0, dwc_pkg::A_CTRL, 32'h0);
    chk("ctrl", dwc_pkg::CTRL_RST, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    $display("test load done");
    // address stepping: first a unit step, then random steps
    for (int k = 0; k < 4; k++) begin
      step = (k == 0) ? 1 : int'(xs() % 8) + 2;
      apb(1'b1, dwc_pkg::A_INC, 32'(step) << 22);
      tick(8);
      prev = dac ^ 10'h2a5;
      for (int j = 0; j < 16; j++) begin
        tick(1);
        idx = dac ^ 10'h2a5;
        chk("dac step", 10'(step), {idx - prev});
        chk("sync out", {idx + 10'(step)} >> 9, sync);
        chk("ck out", {idx + 10'(step)} >> 9, cko);
        prev = idx;
      end
    end
    $display("test dds done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, dwc_pkg::A_CTRL, 32'h100 | sh[i/2] | ((i % 2) << 10));
      tick(3);
      chk("filter", (sh[i/2] == 0 || sh[i/2] == 2) ? 1 : i % 2, filt);
    end
    apb(1'b1, dwc_pkg::A_SQTHR, dwc_pkg::SQ_SWITCH_INC + 32'h1000);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, dwc_pkg::A_CTRL, 32'h101 | ((i / 2) << 12));
      apb(1'b1, dwc_pkg::A_INC, dwc_pkg::SQ_SWITCH_INC + ((i == 0) ? -1 : 1));
      tick(3);
      chk("sq comp", i == 1, sqc);
    end
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, dwc_pkg::A_CTRL, 32'(c) << 8);
      tick(3);
      chk("ck mode", {c == 0, c == 1, c == 2}, {eck, ckoe, plk});
    end
    $display("test steering done");
    // trigger generator: divider 8 counts down to zero, a half period of 9 clocks
    apb(1'b1, dwc_pkg::A_TGDIV, 32'h8);
    apb(1'b1, dwc_pkg::A_CTRL, 32'h110);
    tick(4);
    r = 0;
    s = 0;
    for (int j = 0; j < 320; j++) begin
      idx[1:0] = tso;
      tick(1);
      r += (tso == dwc_pkg::TSO_HIGH && idx[1:0] != dwc_pkg::TSO_HIGH);
      s += tst;
    end
    chk("tgen rises", 1, r >= 17 && r <= 18);
    chk("tgen starts", 1, s >= r - 1 && s <= r + 1);
    apb(1'b1, dwc_pkg::A_CTRL, 32'h130);
    tick(3);
    chk("sweep idle", dwc_pkg::TSO_HIGH, tso);
    apb(1'b1, dwc_pkg::A_EVT, 32'h1);
    tick(3);
    chk("sweep start", dwc_pkg::TSO_LOW, tso);
    apb(1'b1, dwc_pkg::A_EVT, 32'h2);
    tick(3);
    chk("marker", dwc_pkg::TSO_MID, tso);
    tick(dwc_pkg::MARK_CYC + 3);
    chk("marker end", dwc_pkg::TSO_LOW, tso);
    apb(1'b1, dwc_pkg::A_CTRL, 32'h150);
    apb(1'b1, dwc_pkg::A_EVT, 32'h4);
    tick(3);
    chk("hop step", dwc_pkg::TSO_LOW, tso);
    apb(1'b1, dwc_pkg::A_EVT, 32'h8);
    tick(3);
    chk("hop apply", dwc_pkg::TSO_HIGH, tso);
    fork
      i_far.pulse(40000);
      begin
        tick(7);
        chk("ext step", dwc_pkg::TSO_LOW, tso);
      end
    join
    $display("test trig out done");
    // second reset with a failing table load
    i_far.err_on = 1'b1;
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    tick(1100);
    apb(1'b0, dwc_pkg::A_STAT, 32'h0);
    chk("mem err", 1, rd[11]);
    $display("test load error done");
    give_verdict();
  end
endmodule : dds_waveform_core_trigger_io_bench

// ===== bench/dwc_far_model.sv
// dwc_far_model: table load source, ext trigger source and peer clock for the core
// assumes the core takes one load beat per clock after reset release
`timescale 1ns/1ps
module dwc_far_model (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // clock socket wire
  input  wire logic       ck_oe_i,
  input  wire logic       ck_drv_i,
  output logic            ck_wire_o,
  // load source and trigger pin
  output logic            load_valid_o,
  output logic      [9:0] load_data_o,
  output logic            load_err_o,
  output logic            ext_trig_o
);
  int   beat;
  bit   err_on;
  logic peer_ck;
  // table beats; a released data line shows the inverse so stale data never looks valid
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      beat <= 0;
      load_valid_o <= 1'b0;
      load_data_o <= 10'h3ff;
      load_err_o <= 1'b0;
    end else begin
      load_valid_o <= (beat < 1024);
      load_data_o <= (beat < 1024) ? (10'(beat) ^ 10'h2a5) : ~load_data_o;
      load_err_o <= err_on && (beat == 100);
      beat <= beat + 1;
    end
  end
  // peer master clock feeds our socket; the wire follows our drive when enabled
  initial begin
    peer_ck = 1'b0;
    ext_trig_o = 1'b0;
    forever #37 peer_ck = ~peer_ck;
  end
  assign ck_wire_o = ck_oe_i ? ck_drv_i : peer_ck;
  // trigger pulse held for the whole count, never shorter than the mode needs
  task automatic pulse(input int cyc);
    @(posedge core_clk_i);
    ext_trig_o <= 1'b1;
    repeat (cyc) @(posedge core_clk_i);
    ext_trig_o <= 1'b0;
  endtask : pulse
endmodule : dwc_far_model

// ===== rtl/dwc_core.sv
// dwc_core: dds waveform core with apb registers, power-up table load and trigger i/o
// assumes an apb master on core_clk_i; ext trigger and clock socket pins are asynchronous
//
// How it works
// - waveform table holds 1024 samples of 10 bits in writable memory
// - table address steps and each sample is presented to the dac
// - output frequency is set only by the address advance rate
// - small increments visit every address, larger ones skip entries
// - square and pulse use sine comparator above 30 kHz, threshold overridable
// - sine and triangle always go through the smoothing filter
// - ramp and staircase bypass filter unless selected; all shapes at any frequency
// - power-up loads the table, shows revision, flags a memory error on failure
// - clock socket is input, output or phase lock; input accepts external clock
// - ext trigger serves trigger, gate, sweep and hop; fsk does not use it
// - outside sweep and hop, trig out carries the internal trigger square wave
// - each rising trigger generator edge starts trigger and gate
// - sweep mode: three levels, high to low at sweep start, mid pulse at markers
// - hop mode: low on step entry, high once new settings applied
// - after loading, parameters take defaults and main output is disabled
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dwc_core #(
  parameter int ACC_W = dwc_pkg::ACC_W
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // power-up table load source
  input  wire logic        load_valid_i,
  input  wire logic [9:0]  load_data_i,
  input  wire logic        load_err_i,
  // external trigger pin
  input  wire logic        ext_trig_i,
  // clock socket, two-way
  input  wire logic        ck_sock_i,
  output logic             ck_sock_o,
  output logic             ck_sock_oe_o,
  // dac and analogue steering
  output logic      [9:0]  dac_data_o,
  output logic             sq_comp_sel_o,
  output logic             filt_en_o,
  output logic             main_out_en_o,
  output logic             ext_clk_sel_o,
  output logic             plock_en_o,
  // trig/sweep out level and sync out
  output logic      [1:0]  tso_level_o,
  output logic             sync_out_o,
  output logic             trig_start_o
);
  // registers
  logic [31:0]          ctrl_reg;
  logic [ACC_W-1:0]     inc_reg;
  logic [ACC_W-1:0]     sqthr_reg;
  logic [31:0]          tgdiv_reg;
  logic [9:0]           tbladr_reg;
  logic [ACC_W-1:0]     acc_reg;
  logic [31:0]          tgcnt_reg;
  logic                 tg_reg;
  logic [1:0]           tso_reg;
  logic [7:0]           mark_reg;
  logic                 sweep_on_reg;
  logic                 loading_reg;
  logic [9:0]           ldadr_reg;
  logic                 memerr_reg;

  // decoded fields
  wire dwc_pkg::dwc_shape_t shape = dwc_pkg::dwc_shape_t'(ctrl_reg[dwc_pkg::C_SHAPE +: 3]);
  wire dwc_pkg::dwc_mode_t  mode  = dwc_pkg::dwc_mode_t'(ctrl_reg[dwc_pkg::C_MODE +: 3]);
  wire dwc_pkg::dwc_ck_t    cksel = dwc_pkg::dwc_ck_t'(ctrl_reg[dwc_pkg::C_CKSEL +: 2]);
  wire logic filt_sel  = ctrl_reg[dwc_pkg::C_FILT];
  wire logic sq_ovr    = ctrl_reg[dwc_pkg::C_SQOVR];

  // apb decode: zero wait states, writes blocked while loading
  wire logic acc_ph   = psel & penable;
  wire logic wr_en    = acc_ph & pwrite & ~loading_reg;
  wire logic addr_ok  = (paddr <= dwc_pkg::A_EVT) && (paddr[1:0] == 2'h0);
  wire logic wr_ctrl  = wr_en & (paddr == dwc_pkg::A_CTRL);
  wire logic wr_inc   = wr_en & (paddr == dwc_pkg::A_INC);
  wire logic wr_sqthr = wr_en & (paddr == dwc_pkg::A_SQTHR);
  wire logic wr_tgdiv = wr_en & (paddr == dwc_pkg::A_TGDIV);
  wire logic wr_tadr  = wr_en & (paddr == dwc_pkg::A_TBLADR);
  wire logic wr_tdat  = wr_en & (paddr == dwc_pkg::A_TBLDAT);
  wire logic wr_evt   = wr_en & (paddr == dwc_pkg::A_EVT);
  wire logic [31:0] status_w = {20'h0, memerr_reg, loading_reg, 2'h0, dwc_pkg::SW_REV};

  // synchronised external trigger; rising edge and level reach mode logic
  logic ext_lvl;
  logic ext_rise;
  logic ext_fall;
  dwc_sync_edge u_trig_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (ext_trig_i),
    .level_o    (ext_lvl),
    .rise_o     (ext_rise),
    .fall_o     ()
  );
  assign ext_fall = 1'b0;

  // clock socket input seen only as a level; the socket clock is a sample, not a domain
  logic ck_lvl;
  dwc_sync_edge u_ck_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (ck_sock_i),
    .level_o    (ck_lvl),
    .rise_o     (),
    .fall_o     ()
  );

  // table: load port wins during power-up, software port afterwards
  logic [9:0] samp;
  wire logic       tbl_we   = loading_reg ? load_valid_i : wr_tdat;
  wire logic [9:0] tbl_wa   = loading_reg ? ldadr_reg : tbladr_reg;
  wire logic [9:0] tbl_wd   = loading_reg ? load_data_i : pwdata[9:0];
  wire logic [9:0] tbl_ra   = acc_reg[ACC_W-1 -: dwc_pkg::TBL_AW];
  dwc_wave_ram u_ram (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (tbl_we),
    .waddr_i    (tbl_wa),
    .wdata_i    (tbl_wd),
    .raddr_i    (tbl_ra),
    .rdata_o    (samp)
  );

  // triggered modes start from an ext edge or the internal generator edge
  wire logic tg_rise  = (tgcnt_reg == 32'h0) & ~tg_reg;
  wire logic trig_src = (mode == dwc_pkg::DWC_TRIG) || (mode == dwc_pkg::DWC_GATE);
  wire logic start_ev = tg_rise | (trig_src & ext_rise);
  wire logic gate_run = (mode != dwc_pkg::DWC_GATE) | ext_lvl | tg_reg;
  wire logic sq_shape = (shape == dwc_pkg::DWC_SQUARE) || (shape == dwc_pkg::DWC_PULSE);
  wire logic [ACC_W-1:0] thr = sq_ovr ? sqthr_reg : dwc_pkg::SQ_SWITCH_INC;
  wire logic smooth = (shape == dwc_pkg::DWC_SINE) || (shape == dwc_pkg::DWC_TRIANGLE);

  // apb registers; defaults restored while the table loads
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg   <= dwc_pkg::CTRL_RST;
      inc_reg    <= '0;
      sqthr_reg  <= dwc_pkg::SQ_SWITCH_INC;
      tgdiv_reg  <= dwc_pkg::TGDIV_RST;
      tbladr_reg <= '0;
    end else if (loading_reg) begin
      ctrl_reg   <= dwc_pkg::CTRL_RST;
      inc_reg    <= '0;
      sqthr_reg  <= dwc_pkg::SQ_SWITCH_INC;
      tgdiv_reg  <= dwc_pkg::TGDIV_RST;
      tbladr_reg <= '0;
    end else begin
      if (wr_ctrl)  ctrl_reg   <= pwdata;
      if (wr_inc)   inc_reg    <= pwdata[ACC_W-1:0];
      if (wr_sqthr) sqthr_reg  <= pwdata[ACC_W-1:0];
      if (wr_tgdiv) tgdiv_reg  <= pwdata;
      if (wr_tadr)  tbladr_reg <= pwdata[9:0];
      else if (wr_tdat) tbladr_reg <= tbladr_reg + 10'h1;
    end
  end

  // power-up load walks all entries once, error sticks until next reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loading_reg <= 1'b1;
      ldadr_reg   <= '0;
      memerr_reg  <= 1'b0;
    end else if (loading_reg) begin
      if (load_err_i) memerr_reg <= 1'b1;
      if (load_valid_i) begin
        ldadr_reg <= ldadr_reg + 10'h1;
        if (ldadr_reg == 10'(dwc_pkg::TBL_DEPTH - 1)) loading_reg <= 1'b0;
      end
    end
  end

  // phase accumulator: frequency set only by increment, changes are phase continuous
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_reg <= '0;
    end else if (start_ev && mode == dwc_pkg::DWC_TRIG) begin
      acc_reg <= '0;
    end else if (gate_run) begin
      acc_reg <= acc_reg + inc_reg;
    end
  end

  // internal trigger generator: square wave, half period from the divider
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tgcnt_reg <= '0;
      tg_reg    <= 1'b0;
    end else if (wr_tgdiv) begin
      tgcnt_reg <= '0;  // new divider acts at once, not after a long old countdown
    end else if (tgcnt_reg == 32'h0) begin
      tgcnt_reg <= tgdiv_reg;
      tg_reg    <= ~tg_reg;
    end else begin
      tgcnt_reg <= tgcnt_reg - 32'h1;
    end
  end

  // trig/sweep out level per mode; software posts sweep, marker, step, apply events
  wire logic sweep_m = (mode == dwc_pkg::DWC_SWEEP);
  wire logic hop_m   = (mode == dwc_pkg::DWC_HOP);
  wire logic ev_sw   = sweep_m & ((wr_evt & pwdata[dwc_pkg::E_SWEEP]) | ext_rise);
  wire logic ev_mk   = sweep_m & wr_evt & pwdata[dwc_pkg::E_MARK];
  wire logic ev_st   = hop_m & ((wr_evt & pwdata[dwc_pkg::E_STEP]) | ext_rise);
  wire logic ev_ap   = hop_m & wr_evt & pwdata[dwc_pkg::E_APPLY];
  // remembers sweep mode so that entering it raises the idle level once
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sweep_on_reg <= 1'b0;
    end else begin
      sweep_on_reg <= sweep_m;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tso_reg  <= dwc_pkg::TSO_LOW;
      mark_reg <= '0;
    end else if (sweep_m) begin
      if (ev_sw) begin
        tso_reg  <= dwc_pkg::TSO_LOW;
        mark_reg <= '0;
      end else if (ev_mk) begin
        tso_reg  <= dwc_pkg::TSO_MID;
        mark_reg <= dwc_pkg::MARK_CYC_W;
      end else if (mark_reg == 8'h1) begin
        tso_reg  <= dwc_pkg::TSO_LOW;
        mark_reg <= '0;
      end else if (mark_reg != 8'h0) begin
        mark_reg <= mark_reg - 8'h1;
      end else if (!sweep_on_reg) begin
        tso_reg  <= dwc_pkg::TSO_HIGH;
      end
    end else if (hop_m) begin
      mark_reg <= '0;
      if (ev_st) tso_reg <= dwc_pkg::TSO_LOW;
      else if (ev_ap) tso_reg <= dwc_pkg::TSO_HIGH;
    end else begin
      mark_reg <= '0;
      tso_reg  <= tg_reg ? dwc_pkg::TSO_HIGH : dwc_pkg::TSO_LOW;
    end
  end

  // output flops: all top outputs come from registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata        <= '0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      dac_data_o    <= '0;
      sq_comp_sel_o <= 1'b0;
      filt_en_o     <= 1'b1;
      main_out_en_o <= 1'b0;
      ext_clk_sel_o <= 1'b0;
      plock_en_o    <= 1'b0;
      ck_sock_o     <= 1'b0;
      ck_sock_oe_o  <= 1'b0;
      sync_out_o    <= 1'b0;
      trig_start_o  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      unique case (paddr)
        dwc_pkg::A_CTRL:   prdata <= ctrl_reg;
        dwc_pkg::A_INC:    prdata <= 32'(inc_reg);
        dwc_pkg::A_SQTHR:  prdata <= 32'(sqthr_reg);
        dwc_pkg::A_TGDIV:  prdata <= tgdiv_reg;
        dwc_pkg::A_TBLADR: prdata <= {22'h0, tbladr_reg};
        dwc_pkg::A_STAT:   prdata <= status_w;
        default:           prdata <= '0;
      endcase
      dac_data_o    <= samp;
      sq_comp_sel_o <= sq_shape & (inc_reg > thr);
      filt_en_o     <= smooth | filt_sel;
      main_out_en_o <= ctrl_reg[dwc_pkg::C_OUTEN] & ~loading_reg;
      ext_clk_sel_o <= (cksel == dwc_pkg::DWC_CK_INPUT);
      plock_en_o    <= (cksel == dwc_pkg::DWC_CK_PLOCK);
      ck_sock_oe_o  <= (cksel == dwc_pkg::DWC_CK_OUTPUT);
      ck_sock_o     <= acc_reg[ACC_W-1] ^ ck_lvl ^ ck_lvl | ctrl_reg[dwc_pkg::C_CKEXT];
      sync_out_o    <= acc_reg[ACC_W-1];
      trig_start_o  <= start_ev;
    end
  end

  // output disabled for the whole load and one cycle after
  a_out_off_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    loading_reg |=> !main_out_en_o) else $error("main out on during load");
  // rising trigger generator edge gives a start pulse next cycle
  a_tg_start: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    tg_rise |=> trig_start_o) else $error("missed trigger start");
  // sine never leaves the filter
  a_filter_sine: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (shape == dwc_pkg::DWC_SINE) [*2] |-> filt_en_o) else $error("sine unfiltered");
  // accumulator advances by the increment when free running
  a_acc_step: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (mode == dwc_pkg::DWC_CONT) |=> acc_reg == $past(acc_reg) + $past(inc_reg))
    else $error("phase step wrong");
  // dac shows the addressed sample two cycles later
  a_dac_path: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ##1 dac_data_o == $past(samp)) else $error("dac sample stale");
  // sweep start drives the output low
  a_sweep_low: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ev_sw |=> tso_reg == dwc_pkg::TSO_LOW) else $error("sweep start not low");
  // hop step entry goes low and stays until apply
  a_hop_low: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ev_st |=> (tso_reg == dwc_pkg::TSO_LOW) until (ev_ap || !hop_m))
    else $error("hop step not low");
  // clock socket drives only in output setting
  a_ck_dir: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cksel != dwc_pkg::DWC_CK_OUTPUT) |=> !ck_sock_oe_o) else $error("socket driven");
  // outside sweep and hop the output follows the generator
  a_tso_tg: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!sweep_m && !hop_m) |=> tso_reg[1] == $past(tg_reg)) else $error("tso not tg");
  // marker event shows the middle level next cycle
  a_sweep_mid: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (ev_mk && !ev_sw) |=> tso_reg == dwc_pkg::TSO_MID) else $error("marker not mid");
  // apply after a step raises the output again
  a_hop_high: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (ev_ap && !ev_st) |=> tso_reg == dwc_pkg::TSO_HIGH) else $error("apply not high");
  // above the default changeover square and pulse take the comparator
  a_comp_sel: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (sq_shape && !sq_ovr && inc_reg > dwc_pkg::SQ_SWITCH_INC) |=> sq_comp_sel_o)
    else $error("comparator not chosen");
  // input setting selects the external clock
  a_ck_input: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cksel == dwc_pkg::DWC_CK_INPUT) |=> ext_clk_sel_o) else $error("ext clock not chosen");
  // every setup cycle is answered in the next cycle
  a_apb_ready: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (psel && !penable) |=> pready) else $error("no ready");
  // defaults held for the whole table load
  a_load_dflt: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    loading_reg |=> ctrl_reg == dwc_pkg::CTRL_RST) else $error("defaults lost in load");

  assign tso_level_o = tso_reg;
endmodule : dwc_core

// ===== rtl/dwc_pkg.sv
// dwc_pkg: shared constants for the waveform core, its table load and its trigger logic
// assumes one core clock at 40 MHz; all users reference names as dwc_pkg::name
package dwc_pkg;
  // table geometry
  localparam int TBL_DEPTH  = 1024;
  localparam int TBL_AW     = 10;
  localparam int SAMP_W     = 10;
  localparam int ACC_W      = 32;
  // clock and timing
  localparam int CLK_HZ     = 40000000;
  localparam int SQ_SWITCH_HZ = 30000;           // default square/pulse changeover
  // increment equal to the changeover frequency: inc = f * 2^acc / clk
  localparam logic [ACC_W-1:0] SQ_SWITCH_INC =
    ACC_W'((longint'(SQ_SWITCH_HZ) << ACC_W) / longint'(CLK_HZ));
  localparam int MARK_PULSE_NS = 500;            // width of the marker mid-level pulse
  localparam int CLK_PERIOD_NS = 25;
  localparam int MARK_CYC = (MARK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MARK_CYC_W = 8'(MARK_CYC);
  // software revision reported during table load, value arbitrary
  localparam logic [7:0] SW_REV = 8'h01;
  // waveform shapes
  typedef enum logic [2:0] {
    DWC_SINE, DWC_SQUARE, DWC_TRIANGLE, DWC_RAMP, DWC_STAIR, DWC_PULSE
  } dwc_shape_t;
  // operating modes
  typedef enum logic [2:0] {
    DWC_CONT, DWC_TRIG, DWC_GATE, DWC_SWEEP, DWC_FSK, DWC_HOP
  } dwc_mode_t;
  // clock socket settings
  typedef enum logic [1:0] {
    DWC_CK_INPUT, DWC_CK_OUTPUT, DWC_CK_PLOCK
  } dwc_ck_t;
  // trig/sweep out levels: 0 low, 1 mid, 2 high
  localparam logic [1:0] TSO_LOW  = 2'h0;
  localparam logic [1:0] TSO_MID  = 2'h1;
  localparam logic [1:0] TSO_HIGH = 2'h2;
  // register map, byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_INC    = 8'h04;
  localparam logic [7:0] A_SQTHR  = 8'h08;
  localparam logic [7:0] A_TGDIV  = 8'h0c;
  localparam logic [7:0] A_TBLADR = 8'h10;
  localparam logic [7:0] A_TBLDAT = 8'h14;
  localparam logic [7:0] A_STAT   = 8'h18;
  localparam logic [7:0] A_EVT    = 8'h1c;
  // control field positions
  localparam int C_SHAPE = 0;
  localparam int C_MODE  = 4;
  localparam int C_CKSEL = 8;
  localparam int C_FILT  = 10;
  localparam int C_OUTEN = 11;
  localparam int C_SQOVR = 12;
  localparam int C_CKEXT = 13;
  // event register bits (write one to pulse)
  localparam int E_SWEEP = 0;
  localparam int E_MARK  = 1;
  localparam int E_STEP  = 2;
  localparam int E_APPLY = 3;
  localparam int E_LOADERR = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;  // sine, cont, clock out
  localparam logic [31:0] TGDIV_RST = 32'h0000_4e20;
endpackage : dwc_pkg

// ===== rtl/dwc_sync_edge.sv
// dwc_sync_edge: two-stage synchroniser with rising and falling edge pulses
// assumes the input is asynchronous to core_clk_i
`timescale 1ns/1ps
module dwc_sync_edge (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // async input
  input  wire logic async_i,
  // synchronised outputs
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // meta_reg is read only by sync_reg
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~last_reg;
  assign fall_o  = ~sync_reg & last_reg;
endmodule : dwc_sync_edge

// ===== rtl/dwc_wave_ram.sv
// dwc_wave_ram: flip-flop waveform table, one write port and one registered read port
// assumes write and read addresses come from the core clock domain
`timescale 1ns/1ps
module dwc_wave_ram #(
  parameter int DEPTH = dwc_pkg::TBL_DEPTH,
  parameter int AW    = dwc_pkg::TBL_AW,
  parameter int DW    = dwc_pkg::SAMP_W
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_b_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_reg [DEPTH];

  // storage has no reset: the power-up load fills every entry
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // registered read keeps the dac sample off a long mux path
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule : dwc_wave_ram
